// file: hdl/timer_pkg.sv
package timer_pkg;

   // channel count of this build, anywhere from 1 to 8
   localparam int unsigned NUM_CH  = 8;
   localparam int unsigned CNT_W   = 16;
   localparam int unsigned PS_W    = 3;
   localparam int unsigned DIV_W   = 7;

   // counter landmarks and reset values
   localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
   localparam logic [CNT_W-1:0] CNT_ZERO  = 16'h0000;
   localparam logic [CNT_W-1:0] CNT_ONE   = 16'h0001;
   localparam logic [CNT_W-1:0] CNT_MAX   = 16'hFFFF;
   localparam logic [CNT_W-1:0] CV_RESET  = 16'h0000;
   localparam logic [DIV_W-1:0] DIV_RESET = 7'h00;

   // clock_source_select encodings
   typedef enum logic [1:0] {
      CLK_OFF   = 2'b00,
      CLK_BUS   = 2'b01,
      CLK_FIXED = 2'b10,
      CLK_EXT   = 2'b11
   } clk_src_e;

   // edge_level_select encodings
   localparam logic [1:0] ELS_OFF  = 2'b00;
   localparam logic [1:0] ELS_01   = 2'b01;
   localparam logic [1:0] ELS_10   = 2'b10;
   localparam logic [1:0] ELS_11   = 2'b11;

   // channel_mode_select encodings (bit 1 set means edge_pwm)
   localparam logic [1:0] MS_CAPTURE = 2'b00;
   localparam logic [1:0] MS_COMPARE = 2'b01;

endpackage

// file: hdl/tick_if.sv
`timescale 1ns/1ps
// carries the counting tick from the clock stage to the counter
interface tick_if;
   logic [1:0] src_sel;
   logic [2:0] prescale;
   logic       halt;
   logic       restart;
   logic       tick;

   modport gen  (input src_sel, input prescale, input halt, input restart, output tick);
   modport user (output src_sel, output prescale, output halt, output restart, input tick);
endinterface

// file: hdl/pin_sync3.sv
`timescale 1ns/1ps
// three-stage synchroniser; a change counts once stages two and three agree
module pin_sync3 #(
   parameter int unsigned WIDTH = 1
) (
   input  wire logic             mclk_i,
   input  wire logic             rst_n_i,
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] level_o,
   output logic      [WIDTH-1:0] rise_o,
   output logic      [WIDTH-1:0] fall_o
);
   logic [WIDTH-1:0] s1_ff;
   logic [WIDTH-1:0] s2_ff;
   logic [WIDTH-1:0] s3_ff;
   logic [WIDTH-1:0] lvl_ff;
   logic [WIDTH-1:0] rise_ff;
   logic [WIDTH-1:0] fall_ff;
   wire  [WIDTH-1:0] changed;

   // s1 feeds only s2, so no decision ever sees a metastable stage
   assign changed = ~(s2_ff ^ s3_ff) & (s3_ff ^ lvl_ff);

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         s1_ff   <= '0;
         s2_ff   <= '0;
         s3_ff   <= '0;
         lvl_ff  <= '0;
         rise_ff <= '0;
         fall_ff <= '0;
      end else begin
         s1_ff   <= async_i;
         s2_ff   <= s1_ff;
         s3_ff   <= s2_ff;
         lvl_ff  <= (lvl_ff & ~changed) | (s3_ff & changed);
         rise_ff <= changed & s3_ff;
         fall_ff <= changed & ~s3_ff;
      end
   end

   assign level_o = lvl_ff;
   assign rise_o  = rise_ff;
   assign fall_o  = fall_ff;
endmodule

// file: hdl/count_tick_gen.sv
`timescale 1ns/1ps
// picks the count source and divides it by 1..128 into one-cycle ticks
module count_tick_gen (
   input  wire logic mclk_i,
   input  wire logic rst_n_i,
   input  wire logic fixed_clk_i,
   input  wire logic external_count_clock_i,
   tick_if.gen       tk
);
   logic [timer_pkg::DIV_W-1:0] div_ff;
   logic                        tick_ff;
   logic [1:0]                  src_rise;
   logic                        src_pulse;
   wire  [7:0]                  one_hot;
   wire  [timer_pkg::DIV_W-1:0] div_mask;
   wire                         div_hit;

   // both slow clocks are resynchronised; external must stay below a quarter of mclk
   pin_sync3 #(.WIDTH(2)) u_clk_sync (
      .mclk_i  (mclk_i),
      .rst_n_i (rst_n_i),
      .async_i ({external_count_clock_i, fixed_clk_i}),
      .level_o (),
      .rise_o  (src_rise),
      .fall_o  ()
   );

   // source select and divide ratio decode
   always_comb begin
      unique case (timer_pkg::clk_src_e'(tk.src_sel))
         timer_pkg::CLK_OFF:   src_pulse = 1'b0;
         timer_pkg::CLK_BUS:   src_pulse = 1'b1;
         timer_pkg::CLK_FIXED: src_pulse = src_rise[0];
         timer_pkg::CLK_EXT:   src_pulse = src_rise[1];
      endcase
   end
   assign one_hot  = 8'h01 << tk.prescale;
   assign div_mask = 7'(one_hot - 8'h01);
   assign div_hit  = (div_ff & div_mask) == div_mask;

   // debug halt freezes the divider too, so the phase resumes where it stopped
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i || tk.restart) begin
         div_ff  <= timer_pkg::DIV_RESET;
         tick_ff <= 1'b0;
      end else begin
         tick_ff <= src_pulse && !tk.halt && div_hit;
         if (src_pulse && !tk.halt)
            div_ff <= 7'(div_ff + 7'h01);
      end
   end

   assign tk.tick = tick_ff;
endmodule

// file: hdl/timer_capture_compare_pwm.sv
`timescale 1ns/1ps
// How it works
// R01 - up to eight channels, each independently configured
// R02 - 16-bit counter, free-running or modulo up/down
// R03 - modulo 0x0000 or 0xFFFF counts free-running
// R04 - reading the count never disturbs counting
// R05 - any counter write clears the count
// R06 - count source: bus, synced fixed, external
// R07 - prescaler divides by 1 to 128
// R08 - capture edge copies count, sets flag
// R09 - compare match sets flag, drives pin action
// R10 - edge PWM period modulo+1, duty from value
// R11 - centred PWM counts up then down
// R12 - centred: active down-match, inactive up-match
// R13 - one bit forces centred PWM everywhere
// R14 - PWM values load at modulo-1 to modulo
// R15 - status write resets byte-pair coherency
// R16 - software writes status before channel values
// R17 - one request per channel plus overflow
// R18 - debug mode freezes the counter
// R19 - runs in wait, halts with stopped clocks
// R20 - unused pins revert to general I/O
// R21 - no pin drive when edge or clock off
// R22 - edge PWM active at period start, inactive on match
// R23 - external clock synchronised, max quarter rate
// R24 - requests gated by enables, held until cleared
// R25 - one count per tick, matches on mclk
module timer_capture_compare_pwm (
   input  wire logic                                mclk_i,
   input  wire logic                                rst_n_i,
   input  wire logic [1:0]                          clock_source_select_i,
   input  wire logic [2:0]                          prescale_i,
   input  wire logic                                centered_pwm_select_i,
   input  wire logic [15:0]                         modulo_value_i,
   input  wire logic                                counter_wr_i,
   input  wire logic                                status_control_wr_i,
   input  wire logic                                overflow_irq_en_i,
   input  wire logic                                overflow_clear_i,
   input  wire logic                                debug_halt_i,
   input  wire logic                                fixed_clk_i,
   input  wire logic                                external_count_clock_i,
   input  wire logic [timer_pkg::NUM_CH-1:0][1:0]   channel_mode_select_i,
   input  wire logic [timer_pkg::NUM_CH-1:0][1:0]   edge_level_select_i,
   input  wire logic [timer_pkg::NUM_CH-1:0]        ch_irq_en_i,
   input  wire logic [timer_pkg::NUM_CH-1:0]        ch_flag_clear_i,
   input  wire logic [timer_pkg::NUM_CH-1:0]        cv_wr_hi_i,
   input  wire logic [timer_pkg::NUM_CH-1:0]        cv_wr_lo_i,
   input  wire logic [7:0]                          cv_wr_data_i,
   input  wire logic [timer_pkg::NUM_CH-1:0]        channel_pin_i,
   output logic      [15:0]                         counter_value_o,
   output logic                                     counting_down_o,
   output logic                                     overflow_flag_o,
   output logic                                     overflow_irq_o,
   output logic      [timer_pkg::NUM_CH-1:0][15:0]  channel_value_o,
   output logic      [timer_pkg::NUM_CH-1:0]        ch_flag_o,
   output logic      [timer_pkg::NUM_CH-1:0]        ch_irq_o,
   output logic      [timer_pkg::NUM_CH-1:0]        channel_pin_o,
   output logic      [timer_pkg::NUM_CH-1:0]        channel_pin_oe_o
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);

   tick_if tk ();

   logic [15:0]                 cnt_ff;
   logic                        down_ff;
   logic                        ovf_ff;
   logic                        ovf_irq_ff;
   logic [timer_pkg::NUM_CH-1:0] pin_rise;
   logic [timer_pkg::NUM_CH-1:0] pin_fall;
   wire                         tick;
   wire                         clk_on;
   wire                         centered_pwm;
   wire                         free_run;
   wire  [15:0]                 top;
   wire  [15:0]                 top_m1;
   wire                         at_top;
   wire                         at_zero;
   wire                         turn_dn;
   wire                         turn_up;
   wire                         moving_dn;
   wire  [15:0]                 nxt_cnt;
   wire                         nxt_down;
   wire                         ovf_evt;
   wire                         load_pt;
   wire                         period_start;
   wire                         nxt_ovf;

   // prescaled count source; stop mode simply stops mclk, wait mode changes nothing
   assign tk.src_sel  = clock_source_select_i; // R06 R19
   assign tk.prescale = prescale_i; // R07
   assign tk.halt     = debug_halt_i; // R18
   assign tk.restart  = counter_wr_i;
   assign tick        = tk.tick;

   count_tick_gen u_tick (
      .mclk_i                 (mclk_i),
      .rst_n_i                (rst_n_i),
      .fixed_clk_i            (fixed_clk_i),
      .external_count_clock_i (external_count_clock_i), // R23
      .tk                     (tk)
   );

   // channel pins come from outside, so they get the full three-stage treatment
   pin_sync3 #(.WIDTH(timer_pkg::NUM_CH)) u_pin_sync (
      .mclk_i  (mclk_i),
      .rst_n_i (rst_n_i),
      .async_i (channel_pin_i),
      .level_o (),
      .rise_o  (pin_rise),
      .fall_o  (pin_fall)
   );

   // counter step decode
   assign clk_on    = clock_source_select_i != timer_pkg::CLK_OFF;
   assign centered_pwm      = centered_pwm_select_i; // R13
   assign free_run  = modulo_value_i == timer_pkg::CNT_ZERO ||
                      modulo_value_i == timer_pkg::CNT_MAX; // R03
   assign top       = free_run ? timer_pkg::CNT_MAX : modulo_value_i;
   assign top_m1    = 16'(top - timer_pkg::CNT_ONE);
   assign at_top    = cnt_ff == top;
   assign at_zero   = cnt_ff == timer_pkg::CNT_ZERO;
   assign turn_dn   = centered_pwm && !down_ff && at_top; // R11
   assign turn_up   = centered_pwm && down_ff && at_zero;
   assign moving_dn = turn_dn || (centered_pwm && down_ff && !turn_up);
   assign nxt_cnt   = turn_dn ? top_m1 :
                      turn_up ? timer_pkg::CNT_ONE :
                      moving_dn ? 16'(cnt_ff - timer_pkg::CNT_ONE) :
                      (!centered_pwm && at_top) ? timer_pkg::CNT_ZERO :
                      16'(cnt_ff + timer_pkg::CNT_ONE); // R02
   assign nxt_down  = moving_dn;
   assign ovf_evt   = tick && (centered_pwm ? nxt_cnt == timer_pkg::CNT_ZERO : at_top); // R10
   assign load_pt   = tick && !(centered_pwm && down_ff) && cnt_ff == top_m1; // R14
   assign period_start = tick && !centered_pwm && nxt_cnt == timer_pkg::CNT_ZERO;
   assign nxt_ovf   = ovf_evt | (ovf_ff & ~overflow_clear_i);

   // a counter write beats a tick in the same cycle and also restarts the prescaler
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i || counter_wr_i) begin
         cnt_ff  <= timer_pkg::CNT_RESET; // R05
         down_ff <= 1'b0;
      end else if (tick) begin
         cnt_ff  <= nxt_cnt; // R25
         down_ff <= nxt_down;
      end else if (!centered_pwm) begin
         down_ff <= 1'b0;
      end
   end

   // overflow flag: a new event wins over a clear in the same cycle
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         ovf_ff     <= 1'b0;
         ovf_irq_ff <= 1'b0;
      end else begin
         ovf_ff     <= nxt_ovf;
         ovf_irq_ff <= nxt_ovf & overflow_irq_en_i; // R17 R24
      end
   end

   assign counter_value_o = cnt_ff; // R04
   assign counting_down_o = down_ff;
   assign overflow_flag_o = ovf_ff;
   assign overflow_irq_o  = ovf_irq_ff;

   sequence s_halted2;
      debug_halt_i ##1 (debug_halt_i && !counter_wr_i);
   endsequence

   a_count_write_clear : assert property ( // R05
      counter_wr_i |=> cnt_ff == timer_pkg::CNT_ZERO && !down_ff)
      else $error("counter write did not clear the count");
   a_free_run_wrap : assert property ( // R03
      tick && !counter_wr_i && !centered_pwm && free_run && cnt_ff == timer_pkg::CNT_MAX
      |=> cnt_ff == timer_pkg::CNT_ZERO)
      else $error("free-running counter did not wrap to zero");
   a_modulo_wrap_flag : assert property ( // R02
      tick && !counter_wr_i && !centered_pwm && at_top |=> cnt_ff == timer_pkg::CNT_ZERO && ovf_ff)
      else $error("modulo wrap missed or overflow flag not set");
   a_debug_hold : assert property ( // R18
      s_halted2 |=> $stable(cnt_ff))
      else $error("counter moved during debug halt");
   a_centre_turn : assert property ( // R11
      tick && !counter_wr_i && turn_dn |=> down_ff && cnt_ff == $past(top_m1))
      else $error("centred counter did not turn down at the top");

   // per-channel logic: coherency buffer, capture, compare and pin control
   genvar i;
   for (i = 0; i < timer_pkg::NUM_CH; i++) begin : g_ch // R01
      logic [15:0] cv_ff;
      logic [15:0] buf_ff;
      logic        hi_seen_ff;
      logic        lo_seen_ff;
      logic        pend_ff;
      logic        flag_ff;
      logic        irq_ff;
      logic        pin_ff;
      logic        oe_ff;
      wire  [1:0]  els;
      wire  [1:0]  ms;
      wire         act;
      wire         ic;
      wire         oc;
      wire         ep;
      wire         cap;
      wire         match;
      wire         both;
      wire         apply;
      wire         discard;
      wire         flag_evt;
      wire         nxt_flag;
      wire         oc_pin;
      wire         pwm_pin;
      wire         nxt_pin;

      // mode decode; the centred bit overrides every per-channel mode
      assign els   = edge_level_select_i[i];
      assign ms    = channel_mode_select_i[i];
      assign act   = clk_on && els != timer_pkg::ELS_OFF; // R21
      assign ic    = !centered_pwm && ms == timer_pkg::MS_CAPTURE; // R13
      assign oc    = !centered_pwm && ms == timer_pkg::MS_COMPARE;
      assign ep    = !centered_pwm && ms[1];
      assign cap   = ic && act && ((els[0] && pin_rise[i]) || (els[1] && pin_fall[i])); // R08
      assign match = tick && nxt_cnt == cv_ff; // R25
      assign flag_evt = cap || (match && !ic); // R09 R10 R12
      assign nxt_flag = flag_evt | (flag_ff & ~ch_flag_clear_i[i]);

      // byte pairing: a fresh byte wins over a status write in the same cycle
      assign both    = (hi_seen_ff | cv_wr_hi_i[i]) & (lo_seen_ff | cv_wr_lo_i[i]);
      assign apply   = pend_ff && (!clk_on || (oc && tick) || ((ep || centered_pwm) && load_pt)); // R14
      assign discard = pend_ff && clk_on && ic;

      // pin actions: compare 01 toggle, 10 clear, 11 set; PWM levels follow els[0]
      assign oc_pin  = (els == timer_pkg::ELS_01) ? ~pin_ff : els[0];
      assign pwm_pin = ep   ? (match ? els[0] : (period_start ? ~els[0] : pin_ff)) : // R22
                       (match ? (moving_dn ? ~els[0] : els[0]) : pin_ff); // R12
      assign nxt_pin = !act ? pin_ff :
                       (oc && match) ? oc_pin :
                       (ep || centered_pwm) ? pwm_pin : pin_ff; // R09

      always_ff @(posedge mclk_i) begin
         if (!rst_n_i) begin
            buf_ff     <= timer_pkg::CV_RESET;
            hi_seen_ff <= 1'b0;
            lo_seen_ff <= 1'b0;
            pend_ff    <= 1'b0;
         end else begin
            if (cv_wr_hi_i[i])
               buf_ff[15:8] <= cv_wr_data_i;
            if (cv_wr_lo_i[i])
               buf_ff[7:0] <= cv_wr_data_i;
            hi_seen_ff <= !both && ((hi_seen_ff && !status_control_wr_i) || cv_wr_hi_i[i]); // R15
            lo_seen_ff <= !both && ((lo_seen_ff && !status_control_wr_i) || cv_wr_lo_i[i]); // R15
            pend_ff    <= both || (pend_ff && !apply && !discard && !status_control_wr_i); // R16
         end
      end

      // capture has priority over a buffered load landing in the same cycle
      always_ff @(posedge mclk_i) begin
         if (!rst_n_i) begin
            cv_ff <= timer_pkg::CV_RESET;
         end else if (cap) begin
            cv_ff <= cnt_ff; // R08
         end else if (apply) begin
            cv_ff <= buf_ff;
         end
      end

      // pin stays quiet after reset, and releases whenever the channel is off
      always_ff @(posedge mclk_i) begin
         if (!rst_n_i) begin
            flag_ff <= 1'b0;
            irq_ff  <= 1'b0;
            pin_ff  <= 1'b0;
            oe_ff   <= 1'b0; // R20
         end else begin
            flag_ff <= nxt_flag;
            irq_ff  <= nxt_flag & ch_irq_en_i[i]; // R17 R24
            pin_ff  <= nxt_pin;
            oe_ff   <= act && !ic; // R20 R21
         end
      end

      assign channel_value_o[i]  = cv_ff;
      assign ch_flag_o[i]        = flag_ff;
      assign ch_irq_o[i]         = irq_ff;
      assign channel_pin_o[i]    = pin_ff;
      assign channel_pin_oe_o[i] = oe_ff;

      a_pin_release : assert property ( // R21
         !act |=> !oe_ff)
         else $error("pin driven while channel or clock is off");
      a_capture_copy : assert property ( // R08
         cap |=> cv_ff == $past(cnt_ff) && flag_ff)
         else $error("capture did not copy the count or set the flag");
      a_irq_gate : assert property ( // R24
         flag_ff && ch_irq_en_i[i] && !ch_flag_clear_i[i] |=> irq_ff && flag_ff)
         else $error("enabled channel request not held");
      a_pwm_load : assert property ( // R14
         pend_ff && (ep || centered_pwm) && clk_on && load_pt && !cap |=> cv_ff == $past(buf_ff))
         else $error("buffered value not loaded at modulo step");
      a_edge_pwm_start : assert property ( // R22
         act && ep && period_start && !match |=> pin_ff == !$past(els[0]))
         else $error("edge PWM did not assert at period start");
   end
endmodule

// file: tb/pin_partner.sv
`timescale 1ns/1ps
// far side of the channel pins plus the external count clock source
module pin_partner (
   input  wire logic [timer_pkg::NUM_CH-1:0] drive_lvl_i,
   input  wire logic [timer_pkg::NUM_CH-1:0] drive_en_i,
   input  wire logic [timer_pkg::NUM_CH-1:0] pin_o_i,
   input  wire logic [timer_pkg::NUM_CH-1:0] pin_oe_i,
   input  wire logic                         mclk_i,
   input  wire logic                         ext_run_i,
   output logic      [timer_pkg::NUM_CH-1:0] wire_o,
   output logic                              ext_clk_o
);
   // timer drive wins, then our own drive; a released line floats up to the pull-up
   always_comb begin
      for (int i = 0; i < timer_pkg::NUM_CH; i++) begin
         wire_o[i] = pin_oe_i[i] ? pin_o_i[i] : (drive_en_i[i] ? drive_lvl_i[i] : 1'b1);
      end
   end

   // eighth of the bus rate, off the edge; stands still when not running
   initial begin
      ext_clk_o = 1'b0;
      forever begin
         repeat (4) @(posedge mclk_i);
         #7;
         if (ext_run_i) ext_clk_o = ~ext_clk_o;
      end
   end
endmodule

// file: tb/tb.sv
`timescale 1ns/1ps
module tb;
   localparam int N = timer_pkg::NUM_CH;
   logic                mclk_i;
   logic                rst_n_i;
   logic [1:0]          src;
   logic [2:0]          ps;
   logic [15:0]         mdl;
   logic [7:0]          cv_data;
   logic                centered_pwm, cnt_wr, sc_wr, ov_en, ov_clr, dbg, fix_clk, ext_run, ext_clk;
   logic [N-1:0][1:0]   ms, els;
   logic [N-1:0]        irq_en, fclr, whi, wlo, drv_lvl, drv_en, pin_w;
   logic [15:0]         cnt;
   logic                down, ovf, ov_irq;
   logic [N-1:0][15:0]  cv;
   logic [N-1:0]        flg, irq, pin, oe;
   int                  failures = 0;
   int                  samples_checked = 0;

   timer_capture_compare_pwm dut (
      .mclk_i                 (mclk_i),
      .rst_n_i                (rst_n_i),
      .clock_source_select_i  (src),
      .prescale_i             (ps),
      .centered_pwm_select_i  (centered_pwm),
      .modulo_value_i         (mdl),
      .counter_wr_i           (cnt_wr),
      .status_control_wr_i    (sc_wr),
      .overflow_irq_en_i      (ov_en),
      .overflow_clear_i       (ov_clr),
      .debug_halt_i           (dbg),
      .fixed_clk_i            (fix_clk),
      .external_count_clock_i (ext_clk),
      .channel_mode_select_i  (ms),
      .edge_level_select_i    (els),
      .ch_irq_en_i            (irq_en),
      .ch_flag_clear_i        (fclr),
      .cv_wr_hi_i             (whi),
      .cv_wr_lo_i             (wlo),
      .cv_wr_data_i           (cv_data),
      .channel_pin_i          (pin_w),
      .counter_value_o        (cnt),
      .counting_down_o        (down),
      .overflow_flag_o        (ovf),
      .overflow_irq_o         (ov_irq),
      .channel_value_o        (cv),
      .ch_flag_o              (flg),
      .ch_irq_o               (irq),
      .channel_pin_o          (pin),
      .channel_pin_oe_o       (oe)
   );

   pin_partner far_side (
      .drive_lvl_i (drv_lvl),
      .drive_en_i  (drv_en),
      .pin_o_i     (pin),
      .pin_oe_i    (oe),
      .mclk_i      (mclk_i),
      .ext_run_i   (ext_run),
      .wire_o      (pin_w),
      .ext_clk_o   (ext_clk)
   );

   // bus clock, and a fixed clock whose edges never meet it
   initial begin
      mclk_i = 1'b0;
      forever #12.5 mclk_i = ~mclk_i;
   end
   initial begin
      fix_clk = 1'b0;
      #3;
      forever #150 fix_clk = ~fix_clk;
   end

   // drive and sample 2 ns after the edge so no race with the design's updates
   task automatic tk(input int n);
      repeat (n) @(posedge mclk_i);
      #2;
   endtask
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic zc;
      cnt_wr = 1'b1;
      tk(1);
      cnt_wr = 1'b0;
   endtask
   task automatic fc;
      fclr = '1;
      tk(1);
      fclr = '0;
   endtask
   // status first, once per batch: it also drops a pair still waiting to load
   task automatic scw;
      sc_wr = 1'b1;
      tk(1);
      sc_wr = 1'b0;
   endtask
   task automatic wcv(input int ch, input logic [15:0] v);
      whi[ch] = 1'b1;
      cv_data = v[15:8];
      tk(1);
      whi[ch] = 1'b0;
      wlo[ch] = 1'b1;
      cv_data = v[7:0];
      tk(1);
      wlo[ch] = 1'b0;
   endtask
   task automatic upto(input logic [15:0] v);
      int i;
      i = 0;
      while (cnt !== v && i < 3000) begin
         tk(1);
         i++;
      end
      chk("count reached", cnt, v);
   endtask

   task automatic t_count;
      logic [15:0] c0;
      chk("reset outputs", {oe, flg}, 16'h0000);
      src = 2'b01;
      for (int p = 0; p < 8; p++) begin
         ps = p[2:0];
         tk(3);
         c0 = cnt;
         tk(4 << p);
         chk("prescaled count", cnt, c0 + 16'h0004);
      end
      ps = 3'h0;
      zc();
      chk("count after write", cnt, 16'h0000);
      // prescaler restarts with the write, so the first count lands two edges later
      tk(10);
      chk("free count", cnt, 16'h0009);
      dbg = 1'b1;
      tk(2);
      c0 = cnt;
      tk(10);
      chk("halted count", cnt, c0);
      dbg = 1'b0;
      tk(4);
      chk("resumed", {15'h0, cnt != c0}, 16'h0001);
   endtask

   task automatic t_modulo;
      zc();
      mdl = 16'h0005;
      ov_en = 1'b1;
      upto(16'h0005);
      tk(1);
      chk("wrap", cnt, 16'h0000);
      chk("overflow flag", {15'h0, ovf}, 16'h0001);
      tk(1);
      chk("overflow irq", {15'h0, ov_irq}, 16'h0001);
      ov_clr = 1'b1;
      tk(1);
      ov_clr = 1'b0;
      tk(1);
      chk("overflow cleared", {14'h0, ovf, ov_irq}, 16'h0000);
      mdl = 16'h0000;
   endtask

   // clock off: values land directly, so pairing is visible at once
   task automatic t_pairing;
      src = 2'b00;
      ms[0] = timer_pkg::MS_COMPARE;
      els[0] = 2'b11;
      scw();
      wcv(0, 16'h1234);
      tk(3);
      chk("direct value", cv[0], 16'h1234);
      chk("no drive when off", {15'h0, oe[0]}, 16'h0000);
      whi[0] = 1'b1;
      cv_data = 8'hAB;
      tk(1);
      whi[0] = 1'b0;
      sc_wr = 1'b1;
      tk(1);
      sc_wr = 1'b0;
      wlo[0] = 1'b1;
      cv_data = 8'hCD;
      tk(1);
      wlo[0] = 1'b0;
      tk(3);
      chk("half pair dropped", cv[0], 16'h1234);
   endtask

   // set, clear, toggle and software-only compare side by side
   task automatic t_compare;
      src = 2'b01;
      ms[3:0] = {4{timer_pkg::MS_COMPARE}};
      els[3:0] = {2'b00, 2'b01, 2'b10, 2'b11};
      zc();
      scw();
      for (int c = 0; c < 4; c++) wcv(c, 16'h0040);
      upto(16'h0040);
      chk("compare flags", {12'h0, flg[3:0]}, 16'h000F);
      chk("compare pins", {12'h0, pin[3:0]}, 16'h0005);
      chk("compare drive", {12'h0, oe[3:0]}, 16'h0007);
      fc();
   endtask

   task automatic t_capture;
      logic [15:0] c0;
      irq_en[4] = 1'b1;
      drv_en[6:4] = 3'b111;
      drv_lvl[6:4] = 3'b000;
      tk(6);
      els[6:4] = {2'b11, 2'b10, 2'b01};
      tk(2);
      fc();
      c0 = cnt;
      drv_lvl[6:4] = 3'b111;
      tk(8);
      chk("rise flags", {13'h0, flg[6:4]}, 16'h0005);
      chk("captured", {15'h0, cv[4] - c0 >= 3 && cv[4] - c0 <= 5}, 16'h0001);
      chk("capture irq", {15'h0, irq[4]}, 16'h0001);
      chk("capture no drive", {13'h0, oe[6:4]}, 16'h0000);
      fc();
      drv_lvl[6:4] = 3'b000;
      tk(8);
      chk("fall flags", {13'h0, flg[6:4]}, 16'h0006);
      drv_en = '0;
   endtask

   task automatic t_edge_pwm;
      ms[7:6] = {2'b10, 2'b10};
      els[7:6] = {2'b10, 2'b01};
      mdl = 16'h0009;
      zc();
      scw();
      wcv(7, 16'h0004);
      wcv(6, 16'h0004);
      upto(16'h0009);
      tk(1);
      upto(16'h0009);
      tk(1);
      for (int i = 0; i < 20; i++) begin
         chk("edge pwm", {14'h0, pin[7:6]}, {14'h0, cnt < 16'h0004, cnt >= 16'h0004});
         tk(1);
      end
      wcv(7, 16'h0006);
      tk(2);
      chk("value held", cv[7], 16'h0004);
      upto(16'h0009);
      chk("value loaded", cv[7], 16'h0006);
   endtask

   task automatic t_centered_pwm;
      int q;
      logic [15:0] ec;
      centered_pwm = 1'b1;
      mdl = 16'h0008;
      els[7] = 2'b10;
      zc();
      scw();
      wcv(7, 16'h0005);
      upto(16'h0008);
      tk(1);
      upto(16'h0008);
      tk(1);
      for (int i = 0; i < 32; i++) begin
         q = (i + 9) % 16;
         ec = (q <= 8) ? 16'(q) : 16'(16 - q);
         chk("centred count", cnt, ec);
         if (q != 0 && q != 8) chk("direction", {15'h0, down}, {15'h0, q > 8});
         chk("centred pin", {15'h0, pin[7]}, {15'h0, ec < 16'h0005 || q == 11});
         tk(1);
      end
      chk("all channels pwm", {15'h0, oe[4]}, 16'h0001);
      centered_pwm = 1'b0;
   endtask

   task automatic t_sources;
      logic [15:0] c0;
      mdl = 16'h0000;
      src = 2'b11;
      ext_run = 1'b1;
      tk(20);
      c0 = cnt;
      tk(160);
      chk("external count", cnt, c0 + 16'h0014);
      src = 2'b10;
      tk(30);
      c0 = cnt;
      tk(240);
      chk("fixed count", cnt, c0 + 16'h0014);
      ext_run = 1'b0;
   endtask

   task automatic summarize;
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   // cut a hang short well past the expected two thousand or so cycles
   initial begin
      #(25 * 20000);
      failures++;
      summarize();
   end

   initial begin
      {src, ps, centered_pwm, cnt_wr, sc_wr, ov_en, ov_clr, dbg, ext_run, mdl, cv_data} = '0;
      {ms, els, irq_en, fclr, whi, wlo, drv_lvl, drv_en} = '0;
      rst_n_i = 1'b0;
      tk(16);
      rst_n_i = 1'b1;
      tk(1);
      t_count();
      t_modulo();
      t_pairing();
      t_compare();
      t_capture();
      t_edge_pwm();
      t_centered_pwm();
      t_sources();
      summarize();
   end
endmodule
